// ### design/link_cmd_defs.svh
`ifndef LINK_CMD_DEFS_SVH
`define LINK_CMD_DEFS_SVH

// command word fields
`define CMD_IGNORE_BIT 31
`define CMD_WRITE_BIT 15
`define CMD_ROM_BIT 14
`define CMD_REQUEST_BIT 13
`define CMD_XFER_BIT 12
`define CMD_START_BIT 11
`define CMD_TYPE_HI 10
`define CMD_TYPE_LO 8
`define CMD_PARAM_ADDR_HI 12
`define TYPE_STOP 3'h0
`define TYPE_NORMAL 3'h1
`define TYPE_SETUP 3'h7
`define CMD_STOP_EVERY 16'h0800
`define CMD_IDLE 16'h0000

// host register select codes
`define SEL_CMD 3'h0
`define SEL_DATA 3'h1
`define SEL_CTRL 3'h2
`define SEL_WORD0 3'h3
`define SEL_WORD1 3'h4
`define SEL_WORD2 3'h5

// local parameter addresses and values
`define PARAM_IF_TYPE 13'h0000
`define PARAM_IF_WIDTH 13'h0001
`define PARAM_MAJOR 13'h0002
`define PARAM_MINOR 13'h0003
`define PARAM_GP_IN 13'h0004
`define PARAM_GP_OUT 13'h0005
`define PARAM_PROC_TYPE 13'h0006
`define PARAM_CHANNELS 13'h0007
`define IF_TYPE_VAL 8'h5A // arbitrary code, names no real part
`define IF_WIDTH_VAL 8'h08
`define MAJOR_REV_VAL 8'h01
`define MINOR_REV_VAL 8'h00
`define GP_COUNT_VAL 8'h00
`define PROC_TYPE_VAL 8'hA5 // arbitrary code, names no real part
`define CHANNELS_VAL 8'h08

// control/status word fields
`define CTRL_MODE_HI 31
`define CTRL_MODE_LO 24
`define ST_NOT_READY 7
`define ST_NO_ID 6
`define ST_COM_ERR 5
`define ST_REMOTE_FLT 0
`define LF_REMOTE_FLT 6
`define LF_TIMEOUT 3

// response word layout
`define RSP_WIDTH 105
`define RSP_OK_BIT 104
`define RSP_FLT_HI 103
`define RSP_FLT_LO 96
`define RSP_FIFO_DEPTH 8

// timing
`define CLK_MHZ 200
`define XFER_TIMEOUT_US 500
`define XFER_TIMEOUT_CYCLES (`XFER_TIMEOUT_US * `CLK_MHZ)
`define CHATTER_MS 10
`define CHATTER_CYCLES (`CHATTER_MS * `CLK_MHZ * 1000)

`endif

// ### design/link_cmd_pkg.sv
package link_cmd_pkg;
  typedef enum {ST_IDLE, ST_SCAN, ST_REQ, ST_WAIT, ST_FINISH} seq_state_t;
  typedef enum logic [1:0] {REQ_PROBE, REQ_XFER} req_kind_t;
endpackage

// ### design/link_cmd_if.sv
// Summary of operation
// - command writes with bit 31 set are dropped entirely.
// - one 8-bit data register, low byte of a 32-bit word.
// - parameter read: write address plus bit 13, poll zero, read data.
// - parameter write: wait idle, load data, write address with bits 13 and 15.
// - read-only parameters 0 to 7 describe type, width, revisions, counts, channels.
// - reset or stop-every-channel clears channel state and idles every channel.
// - start probes each masked channel that is stopped and fetches unit, name, pointers.
// - remote is set up; with type normal and without errors zero outputs are sent until first transfer.
// - after start the data register holds a mask of failed channels.
// - first transfer ends zero chatter; host keeps transfers above 20 Hz.
// - 0x0800 halts all traffic and resets all channel variables except the outgoing words and mode bytes.
// - discovery only for channels that were stopped when start arrives.
// - per-channel stop halts masked channels and keeps their variables.
// - transfer sends outgoing words, gathers incoming, clears command when done.
// - after a transfer the data register flags channels with problems.
// - per channel three exchange words in and out plus a control/status word.
// - after start words hold unit number, name, and two contents pointers.
// - pointers read zero without discovery; first transfer replaces setup data.
// - command bits: write 15, rom 14, request 13, transfer 12, start 11, type, mask.
// - command reads back until done, then reads zero.
`include "link_cmd_defs.svh"

module rsp_fifo #(
  parameter int WIDTH = `RSP_WIDTH,
  parameter int DEPTH = `RSP_FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;
  wire [AW:0] next_count = count + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count <= '0;
      wr_ptr <= '0;
      rd_ptr <= '0;
      in_ready_o <= 1'b1;
      out_valid_o <= 1'b0;
    end else begin
      count <= next_count;
      in_ready_o <= next_count != (AW+1)'(DEPTH);
      out_valid_o <= next_count != '0;
      if (push) wr_ptr <= wr_ptr + AW'(1);
      if (pop) rd_ptr <= rd_ptr + AW'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) mem[wr_ptr] <= in_data_i;
  end

  assign out_data_o = mem[rd_ptr];
endmodule // rsp_fifo

module link_cmd_if #(
  parameter int unsigned XFER_TIMEOUT_CYCLES = `XFER_TIMEOUT_CYCLES,
  parameter int unsigned CHATTER_CYCLES = `CHATTER_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic host_wr_i,
  input wire logic host_rd_i,
  input wire logic [2:0] host_sel_i,
  input wire logic [2:0] host_chan_i,
  input wire logic [31:0] host_wdata_i,
  output logic [31:0] host_rdata_o,
  output logic host_rvalid_o,
  output logic rem_req_valid_o,
  input wire logic rem_req_ready_i,
  output logic [2:0] rem_req_chan_o,
  output link_cmd_pkg::req_kind_t rem_req_kind_o,
  output logic [7:0] rem_req_mode_o,
  output logic [95:0] rem_req_data_o,
  input wire logic rem_rsp_valid_i,
  output logic rem_rsp_ready_o,
  input wire logic [`RSP_WIDTH-1:0] rem_rsp_data_i
);
  function automatic logic [7:0] param_byte(input logic [12:0] addr);
    logic [7:0] v;
    v = 8'h00;
    unique case (addr)
      `PARAM_IF_TYPE: v = `IF_TYPE_VAL;
      `PARAM_IF_WIDTH: v = `IF_WIDTH_VAL;
      `PARAM_MAJOR: v = `MAJOR_REV_VAL;
      `PARAM_MINOR: v = `MINOR_REV_VAL;
      `PARAM_GP_IN: v = `GP_COUNT_VAL;
      `PARAM_GP_OUT: v = `GP_COUNT_VAL;
      `PARAM_PROC_TYPE: v = `PROC_TYPE_VAL;
      `PARAM_CHANNELS: v = `CHANNELS_VAL;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  link_cmd_pkg::seq_state_t state;
  logic [15:0] cmd;
  logic pend;
  logic [7:0] data_byte;
  logic [7:0] seq_mask;
  logic [2:0] seq_idx;
  link_cmd_pkg::req_kind_t seq_kind;
  logic seq_chatter;
  logic seq_normal;
  logic [7:0] fail_mask;
  logic chatter_en;
  logic [31:0] chatter_cnt;
  logic [31:0] tmo_cnt;
  logic [7:0] active;
  logic [7:0] no_id;
  logic [7:0] com_err;
  logic [7:0] ctrl_mode [8];
  logic [7:0] local_flt [8];
  logic [7:0] remote_flt [8];
  logic [31:0] out_w [8][3];
  logic [31:0] in_w [8][3];
  logic f_valid;
  logic [`RSP_WIDTH-1:0] f_data;

  // host command decode
  wire cmd_sel_wr = host_wr_i && host_sel_i == `SEL_CMD;
  wire cmd_wr = cmd_sel_wr && !host_wdata_i[`CMD_IGNORE_BIT];
  wire [15:0] wcmd = host_wdata_i[15:0];
  wire stop_every = cmd_wr && wcmd == `CMD_STOP_EVERY;
  wire cmd_accept = cmd_wr && !stop_every && cmd == `CMD_IDLE;
  wire [2:0] ctype = cmd[`CMD_TYPE_HI:`CMD_TYPE_LO];
  wire is_start = cmd[`CMD_START_BIT] && (ctype == `TYPE_NORMAL || ctype == `TYPE_SETUP);
  wire is_stop = cmd[`CMD_START_BIT] && ctype == `TYPE_STOP;
  wire is_xfer = cmd[`CMD_XFER_BIT] && !cmd[`CMD_START_BIT];
  wire is_param = cmd[`CMD_REQUEST_BIT] && !cmd[`CMD_XFER_BIT] && !cmd[`CMD_START_BIT];
  wire is_param_wr = is_param && cmd[`CMD_WRITE_BIT];

  // sequencer events
  wire dispatch = state == link_cmd_pkg::ST_IDLE && pend;
  wire chatter_tick = chatter_en && chatter_cnt == CHATTER_CYCLES - 1;
  wire chatter_go = state == link_cmd_pkg::ST_IDLE && !pend && chatter_tick;
  wire rsp_take = state == link_cmd_pkg::ST_WAIT && f_valid;
  wire rsp_ok = f_data[`RSP_OK_BIT];
  wire [7:0] rsp_flt = f_data[`RSP_FLT_HI:`RSP_FLT_LO];
  wire tmo_hit = state == link_cmd_pkg::ST_WAIT && !f_valid && tmo_cnt == XFER_TIMEOUT_CYCLES - 1;
  wire step_done = rsp_take || tmo_hit;
  wire step_fail = tmo_hit || (rsp_take && (!rsp_ok || rsp_flt != 8'h00));
  wire last_idx = seq_idx == 3'h7;
  wire is_probe = seq_kind == link_cmd_pkg::REQ_PROBE;
  wire [7:0] start_mask = cmd[7:0] & ~active;
  wire f_ready = state == link_cmd_pkg::ST_WAIT || state == link_cmd_pkg::ST_IDLE;

  rsp_fifo #(
    .WIDTH(`RSP_WIDTH),
    .DEPTH(`RSP_FIFO_DEPTH)
  ) u_rsp_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(rem_rsp_valid_i),
    .in_ready_o(rem_rsp_ready_o),
    .in_data_i(rem_rsp_data_i),
    .out_valid_o(f_valid),
    .out_ready_i(f_ready),
    .out_data_o(f_data)
  );

  // command register, data register and sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= link_cmd_pkg::ST_IDLE;
      cmd <= `CMD_IDLE;
      pend <= 1'b0;
      data_byte <= 8'h00;
      seq_mask <= 8'h00;
      seq_idx <= 3'h0;
      seq_kind <= link_cmd_pkg::REQ_PROBE;
      seq_chatter <= 1'b0;
      seq_normal <= 1'b0;
      fail_mask <= 8'h00;
      chatter_en <= 1'b0;
      tmo_cnt <= 32'h0;
    end else if (stop_every) begin
      state <= link_cmd_pkg::ST_IDLE;
      cmd <= `CMD_IDLE;
      pend <= 1'b0;
      chatter_en <= 1'b0;
    end else begin
      if (cmd_accept) begin
        cmd <= wcmd;
        pend <= 1'b1;
      end
      if (host_wr_i && host_sel_i == `SEL_DATA) data_byte <= host_wdata_i[7:0];
      unique case (state)
        link_cmd_pkg::ST_IDLE: begin
          if (dispatch) begin
            pend <= 1'b0;
            seq_idx <= 3'h0;
            fail_mask <= 8'h00;
            seq_chatter <= 1'b0;
            if (is_start) begin
              seq_mask <= start_mask;
              seq_kind <= link_cmd_pkg::REQ_PROBE;
              seq_normal <= ctype == `TYPE_NORMAL;
              state <= link_cmd_pkg::ST_SCAN;
            end else if (is_xfer) begin
              seq_mask <= cmd[7:0];
              seq_kind <= link_cmd_pkg::REQ_XFER;
              chatter_en <= 1'b0;
              state <= link_cmd_pkg::ST_SCAN;
            end else begin
              if (is_param && !is_param_wr) data_byte <= param_byte(cmd[`CMD_PARAM_ADDR_HI:0]);
              cmd <= `CMD_IDLE;
            end
          end else if (chatter_go) begin
            seq_mask <= active;
            seq_kind <= link_cmd_pkg::REQ_XFER;
            seq_chatter <= 1'b1;
            seq_idx <= 3'h0;
            state <= link_cmd_pkg::ST_SCAN;
          end
        end
        link_cmd_pkg::ST_SCAN: begin
          if (seq_mask[seq_idx]) state <= link_cmd_pkg::ST_REQ;
          else if (last_idx) state <= link_cmd_pkg::ST_FINISH;
          else seq_idx <= seq_idx + 3'h1;
        end
        link_cmd_pkg::ST_REQ: begin
          tmo_cnt <= 32'h0;
          if (rem_req_ready_i) state <= link_cmd_pkg::ST_WAIT;
        end
        link_cmd_pkg::ST_WAIT: begin
          tmo_cnt <= tmo_cnt + 32'h1;
          if (step_done) begin
            if (step_fail) fail_mask[seq_idx] <= 1'b1;
            if (last_idx) begin
              state <= link_cmd_pkg::ST_FINISH;
            end else begin
              seq_idx <= seq_idx + 3'h1;
              state <= link_cmd_pkg::ST_SCAN;
            end
          end
        end
        link_cmd_pkg::ST_FINISH: begin
          state <= link_cmd_pkg::ST_IDLE;
          if (!seq_chatter) begin
            data_byte <= fail_mask;
            cmd <= `CMD_IDLE;
            if (is_probe && seq_normal && fail_mask == 8'h00) chatter_en <= 1'b1;
          end
        end
      endcase
    end
  end

  // zero-output chatter period
  always_ff @(posedge clk_i) begin
    if (rst_i || !chatter_en || chatter_tick) chatter_cnt <= 32'h0;
    else chatter_cnt <= chatter_cnt + 32'h1;
  end

  // request to the link engine
  always_ff @(posedge clk_i) begin
    if (rst_i || stop_every) begin
      rem_req_valid_o <= 1'b0;
      rem_req_chan_o <= 3'h0;
      rem_req_kind_o <= link_cmd_pkg::REQ_PROBE;
      rem_req_mode_o <= 8'h00;
      rem_req_data_o <= 96'h0;
    end else if (state == link_cmd_pkg::ST_SCAN && seq_mask[seq_idx]) begin
      rem_req_valid_o <= 1'b1;
      rem_req_chan_o <= seq_idx;
      rem_req_kind_o <= seq_kind;
      rem_req_mode_o <= ctrl_mode[seq_idx];
      if (seq_chatter || is_probe) rem_req_data_o <= 96'h0;
      else rem_req_data_o <= {out_w[seq_idx][2], out_w[seq_idx][1], out_w[seq_idx][0]};
    end else if (state == link_cmd_pkg::ST_REQ && rem_req_ready_i) begin
      rem_req_valid_o <= 1'b0;
    end
  end

  // per-channel state
  always_ff @(posedge clk_i) begin
    if (rst_i || stop_every) begin
      active <= 8'h00;
      no_id <= 8'h00;
      com_err <= 8'h00;
      for (int c = 0; c < 8; c++) begin
        local_flt[c] <= 8'h00;
        remote_flt[c] <= 8'h00;
        for (int k = 0; k < 3; k++) in_w[c][k] <= 32'h0;
      end
    end else begin
      if (dispatch && is_stop) active <= active & ~cmd[7:0];
      if (step_done) begin
        if (tmo_hit) local_flt[seq_idx][`LF_TIMEOUT] <= 1'b1;
        if (rsp_take) begin
          remote_flt[seq_idx] <= rsp_flt;
          if (rsp_flt != 8'h00) local_flt[seq_idx][`LF_REMOTE_FLT] <= 1'b1;
        end
        if (is_probe) begin
          active[seq_idx] <= rsp_take && rsp_ok;
          no_id[seq_idx] <= !(rsp_take && rsp_ok);
        end else begin
          com_err[seq_idx] <= !(rsp_take && rsp_ok);
        end
        if (rsp_take && rsp_ok && !seq_chatter) begin
          in_w[seq_idx][0] <= f_data[31:0];
          in_w[seq_idx][1] <= f_data[63:32];
          in_w[seq_idx][2] <= f_data[95:64];
        end
      end
    end
  end

  // host-written outgoing words and mode bytes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int c = 0; c < 8; c++) begin
        ctrl_mode[c] <= 8'h00;
        for (int k = 0; k < 3; k++) out_w[c][k] <= 32'h0;
      end
    end else if (host_wr_i) begin
      if (host_sel_i == `SEL_CTRL) ctrl_mode[host_chan_i] <= host_wdata_i[`CTRL_MODE_HI:`CTRL_MODE_LO];
      if (host_sel_i == `SEL_WORD0) out_w[host_chan_i][0] <= host_wdata_i;
      if (host_sel_i == `SEL_WORD1) out_w[host_chan_i][1] <= host_wdata_i;
      if (host_sel_i == `SEL_WORD2) out_w[host_chan_i][2] <= host_wdata_i;
    end
  end

  // read mux
  wire [7:0] rd_status = {!active[host_chan_i], no_id[host_chan_i], com_err[host_chan_i], 4'h0,
                          remote_flt[host_chan_i] != 8'h00};
  wire [7:0] rd_state_code = {active[host_chan_i], chatter_en, 3'h0, 3'(state)};
  wire [31:0] rd_ctrl = {remote_flt[host_chan_i], rd_state_code, rd_status, local_flt[host_chan_i]};
  wire [31:0] rd_word = host_sel_i == `SEL_CMD ? {16'h0000, cmd} :
                        host_sel_i == `SEL_DATA ? {24'h000000, data_byte} :
                        host_sel_i == `SEL_CTRL ? rd_ctrl :
                        host_sel_i == `SEL_WORD0 ? in_w[host_chan_i][0] :
                        host_sel_i == `SEL_WORD1 ? in_w[host_chan_i][1] :
                        host_sel_i == `SEL_WORD2 ? in_w[host_chan_i][2] : 32'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      host_rdata_o <= 32'h0;
      host_rvalid_o <= 1'b0;
    end else begin
      host_rvalid_o <= host_rd_i;
      if (host_rd_i) host_rdata_o <= rd_word;
    end
  end
endmodule // link_cmd_if

// ### testbench/link_cmd_assertions.sv
`include "link_cmd_defs.svh"

module link_cmd_chk #(
  parameter int unsigned XFER_TIMEOUT_CYCLES = 1,
  parameter int unsigned CHATTER_CYCLES = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic host_wr_i,
  input wire logic host_rd_i,
  input wire logic [2:0] host_sel_i,
  input wire logic [31:0] host_wdata_i,
  input wire logic [31:0] host_rdata_o,
  input wire logic host_rvalid_o,
  input wire logic rem_req_valid_o,
  input wire logic rem_req_ready_i,
  input wire logic [2:0] rem_req_chan_o,
  input wire link_cmd_pkg::req_kind_t rem_req_kind_o,
  input wire logic [95:0] rem_req_data_o,
  input wire logic rem_rsp_ready_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire stop_wr = host_wr_i && host_sel_i == `SEL_CMD && host_wdata_i == 32'h0000_0800;
  wire taken = rem_req_valid_o && rem_req_ready_i;
  wire probe = rem_req_valid_o && rem_req_kind_o == link_cmd_pkg::REQ_PROBE;

  read_answer_a: assert property (host_rd_i |=> host_rvalid_o)
    else $error("read not answered");
  answer_cause_a: assert property (host_rvalid_o |-> $past(host_rd_i))
    else $error("read answer without read");
  cmd_upper_zero_a: assert property (host_rvalid_o && $past(host_sel_i) == `SEL_CMD
    |-> host_rdata_o[31:16] == 16'h0)
    else $error("command upper bits set");
  data_upper_zero_a: assert property (host_rvalid_o && $past(host_sel_i) == `SEL_DATA
    |-> host_rdata_o[31:8] == 24'h0)
    else $error("data upper bits set");
  req_hold_a: assert property (rem_req_valid_o && !rem_req_ready_i && !stop_wr
    |=> rem_req_valid_o && $stable(rem_req_chan_o) && $stable(rem_req_data_o))
    else $error("request changed before accept");
  probe_zero_a: assert property (probe |-> rem_req_data_o == 96'h0)
    else $error("probe carries output data");
  stop_halts_a: assert property (stop_wr |=> !rem_req_valid_o [*2])
    else $error("traffic after stop");
  stop_clears_a: assert property (stop_wr ##1 !host_wr_i ##1 (host_rd_i && host_sel_i == `SEL_CMD)
    |=> host_rdata_o == 32'h0)
    else $error("stop not completed");
  one_outstanding_a: assert property (taken |=> !rem_req_valid_o [*2])
    else $error("request right after accept");
  reset_idle_a: assert property ($fell(rst_i) |-> rem_rsp_ready_o && !rem_req_valid_o)
    else $error("not idle after reset");

  cover property (taken && rem_req_kind_o == link_cmd_pkg::REQ_PROBE);
  cover property (taken && rem_req_kind_o == link_cmd_pkg::REQ_XFER);
  cover property (stop_wr);
endmodule // link_cmd_chk

bind link_cmd_if link_cmd_chk #(.XFER_TIMEOUT_CYCLES(XFER_TIMEOUT_CYCLES), .CHATTER_CYCLES(CHATTER_CYCLES)) chk (
  .clk_i(clk_i), .rst_i(rst_i), .host_wr_i(host_wr_i), .host_rd_i(host_rd_i), .host_sel_i(host_sel_i),
  .host_wdata_i(host_wdata_i), .host_rdata_o(host_rdata_o), .host_rvalid_o(host_rvalid_o),
  .rem_req_valid_o(rem_req_valid_o), .rem_req_ready_i(rem_req_ready_i), .rem_req_chan_o(rem_req_chan_o),
  .rem_req_kind_o(rem_req_kind_o), .rem_req_data_o(rem_req_data_o), .rem_rsp_ready_o(rem_rsp_ready_o));

// ### testbench/remote_model.sv
`include "link_cmd_defs.svh"

module remote_model #(
  parameter logic [31:0] UNIT = 32'h1,
  parameter logic [31:0] NAME = 32'h1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic [2:0] req_chan_i,
  input wire link_cmd_pkg::req_kind_t req_kind_i,
  input wire logic [95:0] req_data_i,
  output logic rsp_valid_o,
  input wire logic rsp_ready_i,
  output logic [`RSP_WIDTH-1:0] rsp_data_o,
  input wire logic [7:0] absent_i,
  input wire logic [7:0] fault_i,
  input wire logic slow_i
);
  logic busy;
  logic [7:0] cnt;
  logic [`RSP_WIDTH-1:0] hold;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_ready_o <= 1'b0;
      rsp_valid_o <= 1'b0;
      busy <= 1'b0;
      cnt <= 8'h00;
      rsp_data_o <= '0;
    end else begin
      req_ready_o <= req_valid_i && !req_ready_o && !busy && !rsp_valid_o;
      if (req_valid_i && req_ready_o) begin
        // missing remote never answers
        busy <= !absent_i[req_chan_i];
        cnt <= slow_i ? 8'h14 : 8'h01;
        if (req_kind_i == link_cmd_pkg::REQ_PROBE)
          hold <= {1'b1, 8'h00, 32'h0, NAME, UNIT};
        else
          hold <= {1'b1, (fault_i[req_chan_i] ? 8'h80 : 8'h00), ~req_data_i};
      end else if (busy && cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
      end else if (busy) begin
        busy <= 1'b0;
        rsp_valid_o <= 1'b1;
        rsp_data_o <= hold;
      end
      if (rsp_valid_o && rsp_ready_i) begin
        rsp_valid_o <= 1'b0;
        rsp_data_o <= ~rsp_data_o;
      end
    end
  end
endmodule // remote_model

// ### testbench/tb.sv
`include "link_cmd_defs.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] UNIT = 32'h0000_0042;
  localparam logic [31:0] NAME = 32'h4443_4241;
  logic clk_i = 0, rst_i = 1, host_wr_i = 0, host_rd_i = 0, slow = 0;
  logic [2:0] host_sel_i = 0, host_chan_i = 0, rem_req_chan_o;
  logic [31:0] host_wdata_i = 0, host_rdata_o, q, seen = 0;
  logic host_rvalid_o, rem_req_valid_o, rem_req_ready_i, rem_rsp_valid_i, rem_rsp_ready_o;
  link_cmd_pkg::req_kind_t rem_req_kind_o;
  logic [7:0] rem_req_mode_o, absent = 0, fault = 0, mode = 0;
  logic [95:0] rem_req_data_o;
  logic [`RSP_WIDTH-1:0] rem_rsp_data_i;
  int mismatches = 0, checked = 0, probes = 0, xfers = 0, n, k;
  logic [15:0] rc [10] = '{16'h2000, 16'h2001, 16'h2002, 16'h2003, 16'h2004, 16'h2005, 16'h2006,
    16'h2007, 16'hA002, 16'h2002};
  logic [7:0] re [10] = '{`IF_TYPE_VAL, `IF_WIDTH_VAL, `MAJOR_REV_VAL, `MINOR_REV_VAL, `GP_COUNT_VAL,
    `GP_COUNT_VAL, `PROC_TYPE_VAL, `CHANNELS_VAL, 8'h00, `MAJOR_REV_VAL};

  always #2.5 clk_i = ~clk_i;

  link_cmd_if #(.XFER_TIMEOUT_CYCLES(50), .CHATTER_CYCLES(100)) dut (.clk_i, .rst_i, .host_wr_i, .host_rd_i,
    .host_sel_i, .host_chan_i, .host_wdata_i, .host_rdata_o, .host_rvalid_o, .rem_req_valid_o,
    .rem_req_ready_i, .rem_req_chan_o, .rem_req_kind_o, .rem_req_mode_o, .rem_req_data_o,
    .rem_rsp_valid_i, .rem_rsp_ready_o, .rem_rsp_data_i);

  remote_model #(.UNIT(UNIT), .NAME(NAME)) far (.clk_i, .rst_i, .req_valid_i(rem_req_valid_o),
    .req_ready_o(rem_req_ready_i), .req_chan_i(rem_req_chan_o), .req_kind_i(rem_req_kind_o),
    .req_data_i(rem_req_data_o), .rsp_valid_o(rem_rsp_valid_i), .rsp_ready_i(rem_rsp_ready_o),
    .rsp_data_o(rem_rsp_data_i), .absent_i(absent), .fault_i(fault), .slow_i(slow));

  always @(posedge clk_i) begin
    if (rem_req_valid_o && rem_req_ready_i) begin
      if (rem_req_kind_o == link_cmd_pkg::REQ_PROBE) begin
        probes++;
        if (rem_req_chan_o == 3'h0)
          mode = rem_req_mode_o;
      end else begin
        xfers++;
        seen = rem_req_data_o[31:0];
      end
    end
  end

  task chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task wr(input logic [2:0] s, input logic [2:0] c, input logic [31:0] d);
    @(negedge clk_i);
    host_sel_i = s;
    host_chan_i = c;
    host_wdata_i = d;
    host_wr_i = 1;
    @(negedge clk_i);
    host_wr_i = 0;
  endtask

  task rd(input logic [2:0] s, input logic [2:0] c);
    @(negedge clk_i);
    host_sel_i = s;
    host_chan_i = c;
    host_rd_i = 1;
    @(negedge clk_i);
    host_rd_i = 0;
    q = host_rdata_o;
  endtask

  task idle;
    n = 0;
    rd(`SEL_CMD, 0);
    while (q !== 32'h0 && n < 900) begin
      rd(`SEL_CMD, 0);
      n++;
    end
    chk(q, 32'h0);
  endtask

  task cmd(input logic [31:0] w);
    wr(`SEL_CMD, 0, w);
    idle();
  endtask

  task conclude;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    conclude();
  end

  initial begin
    repeat (6) @(posedge clk_i);
    @(negedge clk_i) rst_i = 0;
    rd(`SEL_CMD, 0);
    chk(q, 32'h0);
    rd(`SEL_DATA, 0);
    chk(q, 32'h0);
    rd(3'h7, 0);
    chk(q, 32'h0);
    wr(`SEL_DATA, 0, 32'hFFFF_FFAB);
    rd(`SEL_DATA, 0);
    chk(q, 32'h0000_00AB);
    for (int i = 0; i < 10; i++) begin
      wr(`SEL_DATA, 0, 32'h77);
      cmd({16'h0, rc[i]});
      rd(`SEL_DATA, 0);
      if (!rc[i][15])
        chk(q, {24'h0, re[i]});
    end
    wr(`SEL_CMD, 0, 32'h8000_0901);
    rd(`SEL_CMD, 0);
    chk(q, 32'h0);
    wr(`SEL_CTRL, 0, 32'h0300_0000);
    absent = 8'h02;
    wr(`SEL_CMD, 0, 32'h0903);
    rd(`SEL_CMD, 0);
    chk(q, 32'h0903);
    wr(`SEL_CMD, 0, 32'h8000_0800);
    wr(`SEL_CMD, 0, 32'h1001);
    rd(`SEL_CMD, 0);
    chk(q, 32'h0903);
    idle();
    rd(`SEL_DATA, 0);
    chk(q, 32'h02);
    chk(probes, 2);
    chk(mode, 8'h03);
    rd(`SEL_WORD0, 0);
    chk(q, UNIT);
    rd(`SEL_WORD1, 0);
    chk(q, NAME);
    rd(`SEL_WORD2, 0);
    chk(q, 32'h0);
    cmd(32'h0802);
    cmd(32'h0903);
    chk(probes, 3);
    cmd(32'h0800);
    absent = 8'h00;
    cmd(32'h0F01);
    chk(probes, 4);
    repeat (150) @(negedge clk_i);
    chk(xfers, 0);
    cmd(32'h0800);
    cmd(32'h0901);
    chk(probes, 5);
    rd(`SEL_DATA, 0);
    chk(q, 32'h0);
    repeat (300) @(negedge clk_i);
    chk(xfers >= 2, 1);
    chk(seen, 32'h0);
    wr(`SEL_WORD0, 0, 32'h1234_5678);
    cmd(32'h1001);
    chk(seen, 32'h1234_5678);
    rd(`SEL_DATA, 0);
    chk(q, 32'h0);
    rd(`SEL_WORD0, 0);
    chk(q, 32'hEDCB_A987);
    k = xfers;
    repeat (300) @(negedge clk_i);
    chk(xfers, k);
    fault = 8'h01;
    slow = 1;
    cmd(32'h1001);
    rd(`SEL_DATA, 0);
    chk(q, 32'h01);
    absent = 8'h01;
    wr(`SEL_CMD, 0, 32'h1001);
    repeat (5) @(negedge clk_i);
    wr(`SEL_CMD, 0, 32'h0800);
    rd(`SEL_CMD, 0);
    chk(q, 32'h0);
    conclude();
  end
endmodule // tb
